//--- hw/mfr_pkg.sv
// Constants, function codes and types for the multifunction terminal router.
// Assumes one 25 MHz clock, a synchronous active-low reset and no register bus.
// Contract
// - Pin zero offers interrupt A, input 0, output 0, LED, video, audio, event, IRQ.
// - Pin one offers input 1, output 1, LED, low-power flag, video, audio, event, IRQ.
// - Both supply detects high after global reset: pin one carries serial data.
// - Both supply detects high after global reset: pin four carries serial clock.
// - After global reset, read subsystem id and defaults from the EEPROM; the code loads only with both supply detects high and suspend not active.
// - Pin two offers input 2, output 2, LED, video, audio, event, ring, flag, IRQ.
// - Pin three offers IRQ or serialized interrupt; serialized interrupt after reset.
// - Pin four offers lock, input 3, output 3, LED, video, audio, event, flag, ring, IRQ.
// - Pin five offers input 4, output 4, LED, video, audio, flag, event, IRQ.
// - Pin six offers clock-run control or a parallel IRQ.
// - Dedicated output shows ring indicate or power wake event.
// - Host speaker output is the XOR of the socket speaker inputs.
// - While suspended, global or bus reset does not clear the registers.
package mfr_pkg;
	localparam int NUM_PINS = 7;
	localparam int NUM_GP = 5;
	localparam int ROUTE_W = 28;
	localparam int SOCKETS = 2;

	// Routing code held in each four-bit field of the routing word.
	typedef enum logic [3:0] {
		FN_GPI = 4'h0, FN_GPO = 4'h1, FN_LED = 4'h2, FN_VIDEO = 4'h3, FN_AUDIO = 4'h4,
		FN_GPE = 4'h5, FN_PIRQ = 4'h6, FN_LOWPWR = 4'h7, FN_RING = 4'h8, FN_INTA = 4'h9,
		FN_SERIRQ = 4'hA, FN_LOCK = 4'hB, FN_CLKRUN = 4'hC
	} mfr_func_type;

	// Pin three starts as serialized interrupt, pin six as clock run, the rest as inputs.
	localparam logic [ROUTE_W-1:0] ROUTE_RESET = 28'hC00A000;
	localparam logic [15:0] SUBSYS_RESET = 16'h0000;
	localparam logic PME_SEL_RESET = 1'b0;

	// One bit per function code that each pin may carry.
	localparam logic [15:0] ALLOW [NUM_PINS] = '{16'h027F, 16'h00FF, 16'h01FF, 16'h0440,
		16'h09FF, 16'h00FF, 16'h1040};
	// General input/output index per pin; 3'h7 means none.
	localparam logic [2:0] GP_IDX [NUM_PINS] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h3, 3'h4, 3'h7};
	localparam int SDA_PIN = 1;
	localparam int SCL_PIN = 4;

	// Serial bus timing: a quarter of a 100 kHz bit, rounded up to whole clocks.
	localparam int CLK_PERIOD_NS = 40;
	localparam int SCL_QUARTER_NS = 2500;
	localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [7:0] EE_DEV_WR = 8'hA0;
	localparam logic [7:0] EE_DEV_RD = 8'hA1;
	localparam logic [7:0] EE_WORD_ADDR = 8'h00;
	localparam logic [2:0] EE_LAST = 3'h6;
	localparam logic [2:0] EE_SUBSYS_HI = 3'h0;
	localparam logic [2:0] EE_SUBSYS_LO = 3'h1;
	localparam logic [2:0] EE_ROUTE0 = 3'h2;
	localparam logic [2:0] EE_ROUTE1 = 3'h3;
	localparam logic [2:0] EE_ROUTE2 = 3'h4;
	localparam logic [2:0] EE_ROUTE3 = 3'h5;
	localparam logic [2:0] EE_PME = 3'h6;

	typedef enum logic [4:0] {
		LD_IDLE = 5'h01, LD_START = 5'h02, LD_SEND = 5'h04, LD_RECV = 5'h08, LD_STOP = 5'h10
	} mfr_ld_state_type;
endpackage

//--- hw/mfr_load_if.sv
// Link between the router and its EEPROM loader.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface mfr_load_if;
	logic start;
	logic sda_in;
	logic scl_rel;
	logic sda_low;
	logic busy;
	logic byte_vld;
	logic [2:0] byte_idx;
	logic [7:0] byte_data;
	logic err;
	modport loader(input start, input sda_in, output scl_rel, output sda_low, output busy,
		output byte_vld, output byte_idx, output byte_data, output err);
	modport owner(output start, output sda_in, input scl_rel, input sda_low, input busy,
		input byte_vld, input byte_idx, input byte_data, input err);
endinterface

//--- hw/mfr_sync2.sv
// Two-flop synchroniser for pins that arrive from outside the clock domain.
// Assumes the inputs are quasi-static levels; no multi-bit coherence is promised.
`timescale 1ns/1ns
module mfr_sync2 #(
	parameter int WIDTH = 1
) (
	input logic clock_i,
	input logic rst_n_i,
	input logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] safe;
	} mfr_sync_reg_type;
	mfr_sync_reg_type s_reg;
	mfr_sync_reg_type s_next;

	// The first stage feeds only the second stage.
	always_comb begin
		s_next.meta = d_i;
		s_next.safe = s_reg.meta;
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign q_o = s_reg.safe;
endmodule

//--- hw/mfr_ee_loader.sv
// Two-wire EEPROM reader: random read of seven bytes from word address zero.
// Assumes open-drain pins handled by the owner; clock stretching is not honoured.
`timescale 1ns/1ns
module mfr_ee_loader
	import mfr_pkg::*;
(
	input logic clock_i,
	input logic rst_n_i,
	mfr_load_if.loader ld
);
	localparam logic [6:0] QMAX = 7'(SCL_QUARTER_CYC - 1);

	typedef struct packed {
		mfr_ld_state_type st;
		logic [6:0] qcnt;
		logic [1:0] ph;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic [1:0] step;
		logic [2:0] idx;
		logic [2:0] bidx;
		logic scl_rel;
		logic sda_low;
		logic vld;
		logic err;
	} mfr_ld_reg_type;
	mfr_ld_reg_type s_reg;
	mfr_ld_reg_type s_next;
	logic tick;

	// Each bit takes four quarters: set data, raise clock, sample, drop clock.
	always_comb begin
		s_next = s_reg;
		s_next.vld = 1'b0;
		tick = (s_reg.qcnt == QMAX);
		s_next.qcnt = tick ? 7'h00 : s_reg.qcnt + 7'h01;
		if (tick && s_reg.st != LD_IDLE) begin
			s_next.ph = s_reg.ph + 2'h1;
		end
		case (s_reg.st)
			LD_IDLE: begin
				s_next.qcnt = 7'h00;
				s_next.scl_rel = 1'b1;
				s_next.sda_low = 1'b0;
				if (ld.start) begin
					s_next.st = LD_START;
					s_next.ph = 2'h0;
					s_next.step = 2'h0;
					s_next.idx = 3'h0;
					s_next.err = 1'b0;
				end
			end
			LD_START: if (tick) begin
				case (s_reg.ph)
					2'h0: s_next.sda_low = 1'b0;
					2'h1: s_next.scl_rel = 1'b1;
					2'h2: s_next.sda_low = 1'b1;
					default: begin
						s_next.scl_rel = 1'b0;
						s_next.st = LD_SEND;
						s_next.bitn = 4'h0;
						s_next.sh = (s_reg.step == 2'h2) ? EE_DEV_RD : EE_DEV_WR;
					end
				endcase
			end
			LD_SEND: if (tick) begin
				case (s_reg.ph)
					2'h0: s_next.sda_low = (s_reg.bitn < 4'h8) && !s_reg.sh[7];
					2'h1: s_next.scl_rel = 1'b1;
					2'h2: if (s_reg.bitn == 4'h8 && ld.sda_in) s_next.err = 1'b1;
					default: begin
						s_next.scl_rel = 1'b0;
						if (s_reg.bitn < 4'h8) begin
							s_next.sh = {s_reg.sh[6:0], 1'b0};
							s_next.bitn = s_reg.bitn + 4'h1;
						end else if (s_reg.err) begin
							s_next.st = LD_STOP;
						end else if (s_reg.step == 2'h0) begin
							s_next.step = 2'h1;
							s_next.sh = EE_WORD_ADDR;
							s_next.bitn = 4'h0;
						end else if (s_reg.step == 2'h1) begin
							s_next.step = 2'h2;
							s_next.st = LD_START;
						end else begin
							s_next.st = LD_RECV;
							s_next.bitn = 4'h0;
						end
					end
				endcase
			end
			LD_RECV: if (tick) begin
				case (s_reg.ph)
					2'h0: s_next.sda_low = (s_reg.bitn == 4'h8) && (s_reg.idx != EE_LAST);
					2'h1: s_next.scl_rel = 1'b1;
					2'h2: if (s_reg.bitn < 4'h8) s_next.sh = {s_reg.sh[6:0], ld.sda_in};
					default: begin
						s_next.scl_rel = 1'b0;
						if (s_reg.bitn < 4'h8) begin
							s_next.bitn = s_reg.bitn + 4'h1;
						end else begin
							s_next.vld = 1'b1;
							s_next.bidx = s_reg.idx;
							s_next.bitn = 4'h0;
							s_next.idx = s_reg.idx + 3'h1;
							if (s_reg.idx == EE_LAST) s_next.st = LD_STOP;
						end
					end
				endcase
			end
			LD_STOP: if (tick) begin
				case (s_reg.ph)
					2'h0: s_next.sda_low = 1'b1;
					2'h1: s_next.scl_rel = 1'b1;
					2'h2: s_next.sda_low = 1'b0;
					default: s_next.st = LD_IDLE;
				endcase
			end
			default: s_next.st = LD_IDLE;
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			s_reg <= '0;
			s_reg.st <= LD_IDLE;
			s_reg.scl_rel <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign ld.scl_rel = s_reg.scl_rel;
	assign ld.sda_low = s_reg.sda_low;
	assign ld.busy = (s_reg.st != LD_IDLE);
	assign ld.byte_vld = s_reg.vld;
	assign ld.byte_idx = s_reg.bidx;
	assign ld.byte_data = s_reg.sh;
	assign ld.err = s_reg.err;
endmodule

//--- hw/mfr_top.sv
// Multifunction terminal router with serial EEPROM default loading.
// Assumes internal function sources are on clock_i; pins and resets arrive asynchronously.
`timescale 1ns/1ns
module mfr_top (
	input logic clock_i,
	input logic rst_n_i,
	input logic global_reset_input_n_i,
	input logic bus_reset_input_n_i,
	input logic suspend_n_i,
	input logic socket_supply_detect_a_i,
	input logic socket_supply_detect_b_i,
	input logic [mfr_pkg::SOCKETS-1:0] card_speaker_input_i,
	input logic [mfr_pkg::NUM_PINS-1:0] multi_pin_i,
	output logic [mfr_pkg::NUM_PINS-1:0] multi_pin_o,
	output logic [mfr_pkg::NUM_PINS-1:0] multi_pin_oe_o,
	input logic cfg_wr_i,
	input logic [mfr_pkg::ROUTE_W-1:0] cfg_route_i,
	input logic cfg_pme_sel_i,
	input logic inta_n_i,
	input logic [mfr_pkg::NUM_GP-1:0] general_output_i,
	input logic led_i,
	input logic video_port_switch_i,
	input logic audio_pwm_i,
	input logic low_power_state_flag_i,
	input logic ring_i,
	input logic power_wake_event_i,
	input logic [mfr_pkg::NUM_PINS-1:0] par_irq_i,
	input logic serirq_out_i,
	input logic serirq_oe_i,
	input logic clkrun_drive_i,
	output logic [mfr_pkg::NUM_GP-1:0] general_input_o,
	output logic general_purpose_event_o,
	output logic serialized_interrupt_line_o,
	output logic lock_n_o,
	output logic clkrun_n_o,
	output logic ring_indicate_output_o,
	output logic host_speaker_output_o,
	output logic [15:0] subsystem_id_o,
	output logic [mfr_pkg::ROUTE_W-1:0] route_o,
	output logic serial_strap_o,
	output logic eeprom_busy_o,
	output logic eeprom_err_o
);
	import mfr_pkg::*;

	typedef struct packed {
		logic [ROUTE_W-1:0] route;
		logic pme_sel;
		logic [15:0] subsys;
		logic strap;
		logic gres_d;
		logic ld_start;
		logic [NUM_PINS-1:0] prev;
		logic [NUM_PINS-1:0] pin_o;
		logic [NUM_PINS-1:0] pin_oe;
		logic [NUM_GP-1:0] gpi;
		logic general_purpose_event;
		logic lock_n;
		logic clkrun_n;
		logic serirq;
		logic ring;
		logic spk;
		logic busy;
		logic err;
	} mfr_top_reg_type;
	mfr_top_reg_type s_reg;
	mfr_top_reg_type s_next;

	// Field of the routing word that belongs to one pin.
	function automatic mfr_func_type fn_of(input logic [ROUTE_W-1:0] route, input int p);
		return mfr_func_type'(route[4*p +: 4]);
	endfunction

	// True when the pin may carry the code; anything else leaves the pin idle.
	function automatic logic allowed(input int p, input mfr_func_type fn);
		return ALLOW[p][fn];
	endfunction

	// Every external level crosses two flops before use.
	logic [13:0] raw;
	logic [13:0] syn;
	logic gres_s;
	logic bres_s;
	logic susp_n_s;
	logic [1:0] sd_s;
	logic [NUM_PINS-1:0] pin_s;
	logic [SOCKETS-1:0] spk_s;
	logic reset_hit;
	assign raw = {card_speaker_input_i, multi_pin_i, socket_supply_detect_b_i,
		socket_supply_detect_a_i, suspend_n_i, bus_reset_input_n_i, global_reset_input_n_i};
	assign gres_s = syn[0];
	assign bres_s = syn[1];
	assign susp_n_s = syn[2];
	assign sd_s = syn[4:3];
	assign pin_s = syn[11:5];
	assign spk_s = syn[13:12];

	mfr_sync2 #(.WIDTH(14)) u_sync (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.d_i(raw),
		.q_o(syn)
	);

	mfr_load_if ld_bus();

	mfr_ee_loader u_loader (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.ld(ld_bus.loader)
	);

	// The loader samples the data pin only through the synchroniser.
	assign ld_bus.start = s_reg.ld_start;
	assign ld_bus.sda_in = pin_s[SDA_PIN];

	// Suspend shields the configuration from both board resets.
	assign reset_hit = (!gres_s || !bres_s) && susp_n_s;

	always_comb begin
		mfr_func_type fn;
		logic [2:0] gp;
		logic skip;
		fn = FN_GPI;
		gp = 3'h0;
		skip = 1'b0;
		s_next = s_reg;
		s_next.ld_start = 1'b0;
		s_next.gres_d = gres_s;
		s_next.prev = pin_s;

		// Strap and EEPROM load begin at the release of global reset.
		if (gres_s && !s_reg.gres_d) begin
			s_next.strap = sd_s[0] && sd_s[1];
			s_next.ld_start = sd_s[0] && sd_s[1] && susp_n_s;
		end

		// Host writes first, loaded bytes next, board reset wins over both.
		if (cfg_wr_i) begin
			s_next.route = cfg_route_i;
			s_next.pme_sel = cfg_pme_sel_i;
		end
		if (ld_bus.byte_vld) begin
			case (ld_bus.byte_idx)
				EE_SUBSYS_HI: s_next.subsys[15:8] = ld_bus.byte_data;
				EE_SUBSYS_LO: s_next.subsys[7:0] = ld_bus.byte_data;
				EE_ROUTE0: s_next.route[7:0] = ld_bus.byte_data;
				EE_ROUTE1: s_next.route[15:8] = ld_bus.byte_data;
				EE_ROUTE2: s_next.route[23:16] = ld_bus.byte_data;
				EE_ROUTE3: s_next.route[27:24] = ld_bus.byte_data[3:0];
				EE_PME: s_next.pme_sel = ld_bus.byte_data[0];
				default: s_next.pme_sel = s_reg.pme_sel;
			endcase
		end
		if (reset_hit) begin
			s_next.route = ROUTE_RESET;
			s_next.pme_sel = PME_SEL_RESET;
			s_next.subsys = SUBSYS_RESET;
		end
		s_next.busy = ld_bus.busy;
		s_next.err = ld_bus.err;

		// Per-pin routing; only the selected function touches the pin.
		s_next.gpi = '0;
		s_next.general_purpose_event = 1'b0;
		s_next.lock_n = 1'b1;
		s_next.clkrun_n = 1'b1;
		s_next.serirq = 1'b1;
		for (int p = 0; p < NUM_PINS; p++) begin
			fn = fn_of(s_reg.route, p);
			gp = GP_IDX[p];
			skip = s_reg.strap && (p == SDA_PIN || p == SCL_PIN);
			s_next.pin_o[p] = 1'b0;
			s_next.pin_oe[p] = 1'b0;
			if (allowed(p, fn) && !skip) begin
				case (fn)
					FN_GPI: s_next.gpi[gp] = pin_s[p];
					FN_GPE: s_next.general_purpose_event = s_next.general_purpose_event | (s_reg.prev[p] && !pin_s[p]);
					FN_LOCK: s_next.lock_n = pin_s[p];
					FN_GPO: begin
						s_next.pin_o[p] = general_output_i[gp];
						s_next.pin_oe[p] = 1'b1;
					end
					FN_LED: begin
						s_next.pin_o[p] = led_i;
						s_next.pin_oe[p] = 1'b1;
					end
					FN_VIDEO: begin
						s_next.pin_o[p] = video_port_switch_i;
						s_next.pin_oe[p] = 1'b1;
					end
					FN_AUDIO: begin
						s_next.pin_o[p] = audio_pwm_i;
						s_next.pin_oe[p] = 1'b1;
					end
					FN_LOWPWR: begin
						s_next.pin_o[p] = low_power_state_flag_i;
						s_next.pin_oe[p] = 1'b1;
					end
					FN_RING: begin
						s_next.pin_o[p] = ring_i;
						s_next.pin_oe[p] = 1'b1;
					end
					FN_PIRQ: begin
						s_next.pin_o[p] = par_irq_i[p];
						s_next.pin_oe[p] = 1'b1;
					end
					FN_INTA: s_next.pin_oe[p] = !inta_n_i;
					FN_SERIRQ: begin
						s_next.pin_o[p] = serirq_out_i;
						s_next.pin_oe[p] = serirq_oe_i;
						s_next.serirq = pin_s[p];
					end
					FN_CLKRUN: begin
						s_next.pin_oe[p] = clkrun_drive_i;
						s_next.clkrun_n = pin_s[p];
					end
					default: s_next.pin_oe[p] = 1'b0;
				endcase
			end
		end

		// Strapped pins become the open-drain serial bus, pulled low only.
		if (s_reg.strap) begin
			s_next.pin_o[SDA_PIN] = 1'b0;
			s_next.pin_oe[SDA_PIN] = ld_bus.sda_low;
			s_next.pin_o[SCL_PIN] = 1'b0;
			s_next.pin_oe[SCL_PIN] = !ld_bus.scl_rel;
		end

		s_next.ring = s_reg.pme_sel ? power_wake_event_i : ring_i;
		s_next.spk = ^spk_s;
	end

	// The synchronous reset restores every field, strap included.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			s_reg <= '0;
			s_reg.route <= ROUTE_RESET;
			s_reg.pme_sel <= PME_SEL_RESET;
			s_reg.subsys <= SUBSYS_RESET;
			s_reg.lock_n <= 1'b1;
			s_reg.clkrun_n <= 1'b1;
			s_reg.serirq <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign multi_pin_o = s_reg.pin_o;
	assign multi_pin_oe_o = s_reg.pin_oe;
	assign general_input_o = s_reg.gpi;
	assign general_purpose_event_o = s_reg.general_purpose_event;
	assign serialized_interrupt_line_o = s_reg.serirq;
	assign lock_n_o = s_reg.lock_n;
	assign clkrun_n_o = s_reg.clkrun_n;
	assign ring_indicate_output_o = s_reg.ring;
	assign host_speaker_output_o = s_reg.spk;
	assign subsystem_id_o = s_reg.subsys;
	assign route_o = s_reg.route;
	assign serial_strap_o = s_reg.strap;
	assign eeprom_busy_o = s_reg.busy;
	assign eeprom_err_o = s_reg.err;

	// Checks of routing, strap and reset behaviour.
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	a_pin0_gpo: assert property (fn_of(s_reg.route, 0) == FN_GPO |=>
		multi_pin_oe_o[0] && multi_pin_o[0] == $past(general_output_i[0]))
		else $error("pin zero output does not follow general output zero");
	a_pin1_lowpwr: assert property (fn_of(s_reg.route, 1) == FN_LOWPWR && !s_reg.strap |=>
		multi_pin_oe_o[1] && multi_pin_o[1] == $past(low_power_state_flag_i))
		else $error("pin one does not carry the low-power flag");
	a_sda_strap: assert property (s_reg.strap |=>
		!multi_pin_o[1] && multi_pin_oe_o[1] == $past(ld_bus.sda_low))
		else $error("pin one does not follow serial data");
	a_scl_strap: assert property (s_reg.strap |=>
		!multi_pin_o[4] && multi_pin_oe_o[4] == !$past(ld_bus.scl_rel))
		else $error("pin four does not follow serial clock");
	a_load_start: assert property ($rose(gres_s) && sd_s == 2'h3 && susp_n_s |=>
		s_reg.ld_start ##1 ld_bus.busy)
		else $error("strapped global reset release did not start the load");
	a_pin2_ring: assert property (fn_of(s_reg.route, 2) == FN_RING |=>
		multi_pin_oe_o[2] && multi_pin_o[2] == $past(ring_i))
		else $error("pin two does not carry ring indicate");
	a_pin3_default: assert property (disable iff (1'b0) !rst_n_i |=>
		fn_of(s_reg.route, 3) == FN_SERIRQ)
		else $error("pin three is not serialized interrupt after reset");
	a_pin4_lock: assert property (fn_of(s_reg.route, 4) == FN_LOCK && !s_reg.strap |=>
		!multi_pin_oe_o[4] && lock_n_o == $past(pin_s[4]))
		else $error("pin four lock sampling wrong");
	a_pin5_gpi: assert property (fn_of(s_reg.route, 5) == FN_GPI |=>
		!multi_pin_oe_o[5] && general_input_o[4] == $past(pin_s[5]))
		else $error("pin five general input wrong");
	a_pin6_clkrun: assert property (fn_of(s_reg.route, 6) == FN_CLKRUN |=>
		!multi_pin_o[6] && multi_pin_oe_o[6] == $past(clkrun_drive_i))
		else $error("pin six clock-run drive wrong");
	a_ring_pme: assert property (##1 ring_indicate_output_o ==
		($past(s_reg.pme_sel) ? $past(power_wake_event_i) : $past(ring_i)))
		else $error("ring or wake output mismatch");
	a_speaker_xor: assert property (##1 host_speaker_output_o == ^$past(spk_s))
		else $error("speaker output is not the XOR of socket inputs");
	a_suspend_hold: assert property (!susp_n_s && !cfg_wr_i && !ld_bus.byte_vld |=>
		route_o == $past(route_o) && subsystem_id_o == $past(subsystem_id_o))
		else $error("registers changed while suspended");
	a_unsel_idle: assert property (fn_of(s_reg.route, 6) == FN_GPO |=>
		!multi_pin_oe_o[6])
		else $error("pin six drives an unselectable function");

	c_load_done: cover property (ld_bus.byte_vld && ld_bus.byte_idx == EE_LAST);
	c_gpe_event: cover property (general_purpose_event_o);
	c_reroute: cover property (cfg_wr_i ##1 route_o != ROUTE_RESET);
endmodule

//--- dv/mfr_ee_model.sv
// Behavioural serial EEPROM that answers the router's default load.
// Assumes the bench resolves both open-drain lines with pull-ups and feeds them here.
`timescale 1ns/1ns
module mfr_ee_model #(
	parameter logic [55:0] CONTENT = 56'h00000000000000
) (
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_low_o
);
	logic [7:0] dev;
	logic [7:0] ptr;
	logic nak;

	// Take one byte MSB first, then pull the line low for the acknowledge bit.
	// The caller releases the line, so a read can drive its first bit without a second write.
	task automatic rx(output logic [7:0] v);
		repeat (8) @(posedge scl_i) v = {v[6:0], sda_i};
		@(negedge scl_i) sda_low_o = 1'b1;
		@(negedge scl_i);
	endtask

	// A start resynchronises the model, so a restart after the word address just loops.
	initial begin
		sda_low_o = 1'b0;
		ptr = 8'h00;
		forever begin
			@(negedge sda_i iff scl_i);
			rx(dev);
			if (dev == 8'hA0) begin
				sda_low_o = 1'b0;
				rx(ptr);
				sda_low_o = 1'b0;
			end else if (dev == 8'hA1) begin
				nak = 1'b0;
				while (!nak) begin
					// Data changes only while the clock is low, as the bus requires.
					for (int i = 7; i >= 0; i--) begin
						sda_low_o = ~CONTENT[48 - 8 * ptr + i];
						@(posedge scl_i);
						@(negedge scl_i);
					end
					sda_low_o = 1'b0;
					@(posedge scl_i) nak = sda_i;
					@(negedge scl_i);
					ptr = ptr + 8'h01;
				end
			end else begin
				sda_low_o = 1'b0;
			end
		end
	end
endmodule

//--- dv/mfr_top_tb.sv
// Self-checking bench for the multifunction terminal router.
// Assumes pull-ups on the serial lines and the router's package constants.
`timescale 1ns/1ns
module mfr_top_tb;
	import mfr_pkg::*;
	localparam logic [55:0] EE_DATA = 56'h5A3C56A0000C01;
	localparam logic [27:0] EE_ROUTE = {EE_DATA[11:8], EE_DATA[23:16], EE_DATA[31:24], EE_DATA[39:32]};
	typedef struct packed {
		logic [27:0] route;
		logic [6:0] oe;
		logic [6:0] o;
		logic [4:0] gin;
		logic lock_n;
	} mfr_row_type;
	localparam mfr_row_type ROWS [7] = '{'{28'hC31A271, 7'h37, 7'h07, 5'h00, 1'b1},
		'{28'hC78A804, 7'h35, 7'h21, 5'h00, 1'b1}, '{28'hC10A609, 7'h25, 7'h24, 5'h00, 1'b1},
		'{28'hC80A90B, 7'h00, 7'h00, 5'h00, 1'b1}, '{28'h60B6000, 7'h48, 7'h40, 5'h15, 1'b0},
		'{28'hC00A000, 7'h00, 7'h00, 5'h15, 1'b1}, '{28'h1C0A000, 7'h00, 7'h00, 5'h05, 1'b1}};
	logic clock_i, rst_n_i, gres_n, brst_n, susp_n, det_a, det_b, cfg_wr, pme_sel, inta_n;
	logic led, video, audio, lowpwr, ring, pwe, ser_out, ser_oe, clkrun_drv, ee_en, ee_low;
	logic [1:0] spk;
	logic [27:0] cfg_route, route;
	logic [4:0] gpo, gin;
	logic [6:0] par_irq, pin_drv, pin_o, pin_oe;
	logic general_purpose_event, ser_line, lock_n, clkrun_n, ring_indicate_output, spk_out, strap, busy, err;
	logic [15:0] subsys;
	wire [6:0] pin_w;
	int error_cnt = 0;
	int cmp_count = 0;
	int cycles = 0;
	int n;

	// Wire level from every party; released lines fall back to the bench or pull-up.
	assign pin_w = (pin_oe & pin_o | ~pin_oe & pin_drv) & ~{5'h00, ee_low, 1'b0};

	mfr_ee_model #(.CONTENT(EE_DATA)) ee (.scl_i(ee_en ? pin_w[4] : 1'b1), .sda_i(ee_en ? pin_w[1] : 1'b1),
		.sda_low_o(ee_low));

	mfr_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .global_reset_input_n_i(gres_n),
		.bus_reset_input_n_i(brst_n), .suspend_n_i(susp_n), .socket_supply_detect_a_i(det_a),
		.socket_supply_detect_b_i(det_b), .card_speaker_input_i(spk), .multi_pin_i(pin_w),
		.multi_pin_o(pin_o), .multi_pin_oe_o(pin_oe), .cfg_wr_i(cfg_wr), .cfg_route_i(cfg_route),
		.cfg_pme_sel_i(pme_sel), .inta_n_i(inta_n), .general_output_i(gpo), .led_i(led),
		.video_port_switch_i(video), .audio_pwm_i(audio), .low_power_state_flag_i(lowpwr), .ring_i(ring),
		.power_wake_event_i(pwe), .par_irq_i(par_irq), .serirq_out_i(ser_out), .serirq_oe_i(ser_oe),
		.clkrun_drive_i(clkrun_drv), .general_input_o(gin), .general_purpose_event_o(general_purpose_event),
		.serialized_interrupt_line_o(ser_line), .lock_n_o(lock_n), .clkrun_n_o(clkrun_n),
		.ring_indicate_output_o(ring_indicate_output), .host_speaker_output_o(spk_out), .subsystem_id_o(subsys),
		.route_o(route), .serial_strap_o(strap), .eeprom_busy_o(busy), .eeprom_err_o(err));

	// The clock toggles every half period of the 40 ns cycle.
	always #20 clock_i = ~clock_i;

	task automatic cyc(input int k);
		repeat (k) @(negedge clock_i);
	endtask

	task automatic chk(input string nm, input logic [27:0] g, input logic [27:0] e);
		cmp_count++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask

	task automatic wr(input logic [27:0] r, input logic p);
		cfg_route = r;
		pme_sel = p;
		cfg_wr = 1'b1;
		cyc(1);
		cfg_wr = 1'b0;
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// The load takes about 24000 cycles; the ceiling leaves ample margin.
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 60000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	initial begin
		{clock_i, rst_n_i, det_a, det_b, spk, cfg_wr, pme_sel, video, ring, ser_out, ser_oe} = '0;
		{gres_n, brst_n, susp_n, pwe, led, audio, lowpwr} = '1;
		{clkrun_drv, ee_en, cfg_route, gpo, par_irq, pin_drv} = {2'b00, ROUTE_RESET, 5'h15, 7'h45, 7'h25};
		inta_n = 1'b0;
		cyc(3);
		rst_n_i = 1'b1;
		cyc(5);
		chk("route_o", route, ROUTE_RESET);
		ser_oe = 1'b1;
		clkrun_drv = 1'b1;
		cyc(4);
		chk("oe", 28'(pin_oe), 28'h48);
		chk("serial irq", 28'(ser_line), 28'h0);
		chk("clkrun_n", 28'(clkrun_n), 28'h0);
		{ser_oe, clkrun_drv} = 2'b00;
		$display("test reset routing done");
		// Each row routes functions onto pins and checks drives, enables and samples.
		foreach (ROWS[i]) begin
			wr(ROWS[i].route, 1'b0);
			cyc(4);
			chk("oe", 28'(pin_oe), 28'(ROWS[i].oe));
			chk("drive", 28'(pin_o & pin_oe), 28'(ROWS[i].o));
			chk("gin", 28'(gin), 28'(ROWS[i].gin));
			chk("lock_n", 28'(lock_n), 28'(ROWS[i].lock_n));
		end
		$display("test routing table done");
		wr(28'hC00A005, 1'b0);
		cyc(4);
		pin_drv[0] = 1'b0;
		n = 0;
		repeat (6) begin
			cyc(1);
			if (general_purpose_event === 1'b1) n++;
		end
		chk("gpe pulses", 28'(n), 28'h1);
		for (int s = 0; s < 2; s++) begin
			wr(ROUTE_RESET, s[0]);
			cyc(2);
			chk("ring_indicate_output", 28'(ring_indicate_output), 28'(s));
		end
		for (int k = 0; k < 4; k++) begin
			spk = k[1:0];
			cyc(4);
			chk("spk_out", 28'(spk_out), 28'(k[0] ^ k[1]));
		end
		$display("test events and outputs done");
		// Both detects high across a global reset hand pins one and four to the loader.
		{det_a, det_b, ee_en, gres_n, pin_drv} = {4'b1110, 7'h37};
		cyc(4);
		gres_n = 1'b1;
		for (n = 0; n < 20 && busy !== 1'b1; n++) cyc(1);
		chk("busy", 28'(busy), 28'h1);
		for (n = 0; n < 40000 && busy !== 1'b0; n++) cyc(1);
		chk("subsys", 28'(subsys), 28'(EE_DATA[55:40]));
		chk("route_o", route, EE_ROUTE);
		chk("err", 28'(err), 28'h0);
		chk("strap", 28'(strap), 28'h1);
		chk("ring_indicate_output", 28'(ring_indicate_output), 28'(EE_DATA[0]));
		$display("test serial load done");
		// A suspended board reset keeps the loaded values; an unsuspended one clears them.
		susp_n = 1'b0;
		cyc(3);
		brst_n = 1'b0;
		cyc(4);
		brst_n = 1'b1;
		cyc(3);
		chk("route_o", route, EE_ROUTE);
		susp_n = 1'b1;
		cyc(3);
		brst_n = 1'b0;
		cyc(4);
		brst_n = 1'b1;
		cyc(3);
		chk("route_o", route, ROUTE_RESET);
		chk("subsys", 28'(subsys), 28'h0);
		$display("test suspend done");
		tally_and_finish();
	end
endmodule
